// ===== logic/tsr_consts.svh
// Constants for the sensor offset and identification register bank.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// ==========================================================================
// Register offsets
`define TSR_OFF_TEMP 8'h00
`define TSR_OFF_SCRATCH2 8'h06
`define TSR_OFF_OFFSET 8'h07
`define TSR_OFF_SCRATCH3 8'h08
`define TSR_OFF_IDENT 8'h0f

// ==========================================================================
// Field positions and reset values
`define TSR_ID_REV_LSB 12
`define TSR_OFFSET_RST 16'h0000
`define TSR_TEMP_RST 16'h0000
`define TSR_SCRATCH_RST 16'h0000

// ==========================================================================
// Bus addressing
`define TSR_ADDR_BASE 7'h48
`define TSR_GCALL_ADDR 7'h00
`define TSR_GCALL_RESET_CMD 8'h06

// ==========================================================================
// Timing
`define TSR_CLK_MHZ 250
`define TSR_AVG8_TIME_MS 125
`define TSR_AVG8_SAMPLES 8
`define TSR_CONV_CYCLES (`TSR_AVG8_TIME_MS * 1000 * `TSR_CLK_MHZ / `TSR_AVG8_SAMPLES)
`define TSR_GCR_TIME_US 1500
`define TSR_GCR_CYCLES (`TSR_GCR_TIME_US * `TSR_CLK_MHZ)

`endif

// ===== logic/tsr_pkg.sv
// Types shared by the sensor register bank.
package tsr_pkg;

    // ==========================================================================
    // Bus pins and identification word
    typedef struct packed {
        logic scl;
        logic sda;
    } tsr_bus_in_type;

    typedef struct packed {
        logic [3:0] revision;
        logic [11:0] part_identifier_field;
    } tsr_ident_type;

    // ==========================================================================
    // Bus target states
    typedef enum logic [6:0] {
        TSR_ST_IDLE = 7'h01,
        TSR_ST_ADDR = 7'h02,
        TSR_ST_AACK = 7'h04,
        TSR_ST_WRITE = 7'h08,
        TSR_ST_WACK = 7'h10,
        TSR_ST_READ = 7'h20,
        TSR_ST_RACK = 7'h40
    } tsr_state_type;

endpackage : tsr_pkg

// ===== logic/tsr_offset_sat.sv
// Saturating signed adder for the calibration offset.
`timescale 1ns/1ns
module tsr_offset_sat #(
    parameter int WIDTH = 16
) (
    input wire logic signed [WIDTH-1:0] value_in,
    input wire logic signed [WIDTH-1:0] offset_in,
    output logic signed [WIDTH-1:0] value_out
);

    logic signed [WIDTH:0] sum_w;
    wire overflow = sum_w[WIDTH] != sum_w[WIDTH-1];
    wire signed [WIDTH-1:0] max_w = {1'b0, {(WIDTH-1){1'b1}}};
    wire signed [WIDTH-1:0] min_w = {1'b1, {(WIDTH-1){1'b0}}};

    assign sum_w = {value_in[WIDTH-1], value_in} + {offset_in[WIDTH-1], offset_in};
    assign value_out = overflow ? (sum_w[WIDTH] ? min_w : max_w) : sum_w[WIDTH-1:0];

endmodule : tsr_offset_sat

// ===== logic/tsr_regs.sv
// Bus target, offset, scratch and identification registers of the sensor.
`timescale 1ns/1ns
`include "tsr_consts.svh"
module tsr_regs #(
    parameter int CONV_CYCLES = `TSR_CONV_CYCLES,
    parameter int GCR_CYCLES = `TSR_GCR_CYCLES,
    parameter logic [15:0] SCRATCH2_INIT = `TSR_SCRATCH_RST,
    parameter logic [15:0] SCRATCH3_INIT = `TSR_SCRATCH_RST,
    // Identification values are arbitrary.
    parameter logic [3:0] REVISION = 4'h2,
    parameter logic [11:0] PART_ID = 12'h5a3
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire tsr_pkg::tsr_bus_in_type bus_in,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic [1:0] address_select_pin,
    input wire logic nonvolatile_write_unlock,
    input wire logic continuous_conversion_mode,
    input wire logic [1:0] avg_mode,
    input wire logic signed [15:0] limit_high,
    input wire logic signed [15:0] limit_low,
    output logic sample_req,
    input wire logic sample_valid,
    input wire logic signed [15:0] sample_data,
    output logic signed [15:0] temp_result,
    output logic alert_n,
    output logic soft_reset_busy
);

    // ==========================================================================
    // Declarations
    tsr_pkg::tsr_state_type st_r, st_nxt;
    logic scl_q_r, sda_q_r;
    logic [3:0] bit_cnt_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt, rd_shift_r, rd_nxt, ptr_r, msb_r;
    logic [15:0] rd_word_r, rd_word_nxt;
    logic [1:0] byte_idx_r, idx_nxt;
    logic rw_r, rw_nxt, gcall_r, gc_nxt, nack_r, nack_nxt, half_r, half_nxt, wr_stb;
    logic signed [15:0] offset_r, temp_r, sat_w, avg_val;
    logic [15:0] scratch2_r, scratch3_r, nv2_r, nv3_r, read_word;
    logic [31:0] gcr_cnt_r, conv_cnt_r;
    logic signed [21:0] acc_r, acc_nxt, acc_shifted;
    logic [6:0] samp_cnt_r;
    logic sample_req_r, alert_n_r;
    logic signed [16:0] sum_wide;
    tsr_pkg::tsr_ident_type ident_w;

    function automatic logic [2:0] avg_shift(input logic [1:0] mode);
        case (mode)
            2'h0: avg_shift = 3'h0;
            2'h1: avg_shift = 3'h3;
            2'h2: avg_shift = 3'h5;
            default: avg_shift = 3'h6;
        endcase
    endfunction : avg_shift

    // ==========================================================================
    // Bus decoding
    wire scl_rise = bus_in.scl & ~scl_q_r;
    wire scl_fall = ~bus_in.scl & scl_q_r;
    wire bus_start = bus_in.scl & scl_q_r & sda_q_r & ~bus_in.sda;
    wire bus_stop = bus_in.scl & scl_q_r & ~sda_q_r & bus_in.sda;
    wire [6:0] own_addr = `TSR_ADDR_BASE + {5'h00, address_select_pin};
    wire byte_done = bit_cnt_r == 4'h8;
    wire addr_match = shift_r[7:1] == own_addr;
    wire gcall_match = (shift_r[7:1] == `TSR_GCALL_ADDR) & ~shift_r[0];
    wire word_wr = wr_stb & ~gcall_r & (byte_idx_r == 2'h2);
    wire [15:0] wr_word = {msb_r, shift_r};
    wire gcr_cmd = wr_stb & gcall_r & (shift_r == `TSR_GCALL_RESET_CMD);
    wire gcr_busy = gcr_cnt_r != 32'h0;
    wire wr_scr2 = word_wr & (ptr_r == `TSR_OFF_SCRATCH2);
    wire wr_scr3 = word_wr & (ptr_r == `TSR_OFF_SCRATCH3);
    wire wr_off = word_wr & (ptr_r == `TSR_OFF_OFFSET);
    wire [2:0] sh_w = avg_shift(avg_mode);
    wire [6:0] avg_cnt = 7'h1 << sh_w;
    wire res_stb = sample_valid & ~gcr_busy & (samp_cnt_r + 7'h1 == avg_cnt);

    // The identification word ignores writes; it is built from constants only.
    assign ident_w = '{revision: REVISION, part_identifier_field: PART_ID};
    assign read_word = (ptr_r == `TSR_OFF_TEMP) ? temp_r :
                       (ptr_r == `TSR_OFF_SCRATCH2) ? scratch2_r :
                       (ptr_r == `TSR_OFF_OFFSET) ? offset_r :
                       (ptr_r == `TSR_OFF_SCRATCH3) ? scratch3_r :
                       (ptr_r == `TSR_OFF_IDENT) ? ident_w : 16'h0000;

    // Data is only ever pulled low; the pull-up provides the high level.
    assign sda_o = 1'b0;
    assign sda_oe_n = ~((st_r == tsr_pkg::TSR_ST_AACK) | (st_r == tsr_pkg::TSR_ST_WACK) |
                        ((st_r == tsr_pkg::TSR_ST_READ) & ~rd_shift_r[7]));

    // ==========================================================================
    // Bus target state machine
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        rd_nxt = rd_shift_r;
        rd_word_nxt = rd_word_r;
        idx_nxt = byte_idx_r;
        rw_nxt = rw_r;
        gc_nxt = gcall_r;
        nack_nxt = nack_r;
        half_nxt = half_r;
        wr_stb = 1'b0;
        if (bus_start) begin
            st_nxt = tsr_pkg::TSR_ST_ADDR;
            bit_nxt = 4'h0;
            idx_nxt = 2'h0;
        end else if (bus_stop) begin
            st_nxt = tsr_pkg::TSR_ST_IDLE;
        end else begin
            case (st_r)
                tsr_pkg::TSR_ST_ADDR, tsr_pkg::TSR_ST_WRITE: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], bus_in.sda};
                        bit_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (st_r == tsr_pkg::TSR_ST_WRITE) begin
                            st_nxt = tsr_pkg::TSR_ST_WACK;
                            wr_stb = 1'b1;
                            idx_nxt = (byte_idx_r == 2'h2) ? 2'h1 : byte_idx_r + 2'h1;
                        end else if (addr_match || gcall_match) begin
                            st_nxt = tsr_pkg::TSR_ST_AACK;
                            rw_nxt = shift_r[0];
                            gc_nxt = gcall_match;
                        end else begin
                            st_nxt = tsr_pkg::TSR_ST_IDLE;
                        end
                    end
                end
                tsr_pkg::TSR_ST_AACK, tsr_pkg::TSR_ST_WACK: begin
                    if (scl_fall) begin
                        bit_nxt = 4'h0;
                        if (st_r == tsr_pkg::TSR_ST_AACK && rw_r) begin
                            st_nxt = tsr_pkg::TSR_ST_READ;
                            rd_word_nxt = read_word;
                            rd_nxt = read_word[15:8];
                            half_nxt = 1'b1;
                        end else begin
                            st_nxt = tsr_pkg::TSR_ST_WRITE;
                        end
                    end
                end
                tsr_pkg::TSR_ST_READ: begin
                    if (scl_rise) begin
                        bit_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            st_nxt = tsr_pkg::TSR_ST_RACK;
                        end else begin
                            rd_nxt = {rd_shift_r[6:0], 1'b0};
                        end
                    end
                end
                tsr_pkg::TSR_ST_RACK: begin
                    if (scl_rise) begin
                        nack_nxt = bus_in.sda;
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            st_nxt = tsr_pkg::TSR_ST_IDLE;
                        end else begin
                            st_nxt = tsr_pkg::TSR_ST_READ;
                            bit_nxt = 4'h0;
                            rd_nxt = half_r ? rd_word_r[7:0] : rd_word_r[15:8];
                            half_nxt = ~half_r;
                        end
                    end
                end
                default: begin
                    st_nxt = tsr_pkg::TSR_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= tsr_pkg::TSR_ST_IDLE;
            {scl_q_r, sda_q_r} <= 2'h3;
            {bit_cnt_r, shift_r, rd_shift_r, rd_word_r, byte_idx_r} <= 38'h0;
            {rw_r, gcall_r, nack_r, half_r} <= 4'h0;
        end else begin
            st_r <= st_nxt;
            {scl_q_r, sda_q_r} <= {bus_in.scl, bus_in.sda};
            {bit_cnt_r, shift_r, rd_shift_r, rd_word_r, byte_idx_r} <=
                {bit_nxt, shift_nxt, rd_nxt, rd_word_nxt, idx_nxt};
            {rw_r, gcall_r, nack_r, half_r} <= {rw_nxt, gc_nxt, nack_nxt, half_nxt};
        end
    end

    // ==========================================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {ptr_r, msb_r} <= 16'h0;
        end else if (wr_stb && !gcall_r) begin
            if (byte_idx_r == 2'h0) ptr_r <= shift_r;
            if (byte_idx_r == 2'h1) msb_r <= shift_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nv2_r <= SCRATCH2_INIT;
            nv3_r <= SCRATCH3_INIT;
        end else begin
            if (wr_scr2 && nonvolatile_write_unlock) nv2_r <= wr_word;
            if (wr_scr3 && nonvolatile_write_unlock) nv3_r <= wr_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scratch2_r <= SCRATCH2_INIT;
            scratch3_r <= SCRATCH3_INIT;
            offset_r <= `TSR_OFFSET_RST;
        end else if (gcr_cmd) begin
            scratch2_r <= nv2_r;
            scratch3_r <= nv3_r;
            offset_r <= `TSR_OFFSET_RST;
        end else begin
            if (wr_scr2) scratch2_r <= wr_word;
            if (wr_scr3) scratch3_r <= wr_word;
            if (wr_off) offset_r <= wr_word;
        end
    end

    // ==========================================================================
    // General-call reset and sampling
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gcr_cnt_r <= 32'h0;
        end else if (gcr_cmd) begin
            gcr_cnt_r <= 32'(GCR_CYCLES);
        end else if (gcr_busy) begin
            gcr_cnt_r <= gcr_cnt_r - 32'h1;
        end
    end

    // The sample timer is held at zero during reset so all targets restart together.
    always_ff @(posedge core_clk) begin
        if (!rst_n || gcr_busy || !continuous_conversion_mode) begin
            conv_cnt_r <= 32'h0;
            sample_req_r <= 1'b0;
        end else if (conv_cnt_r == 32'h0) begin
            conv_cnt_r <= 32'(CONV_CYCLES - 1);
            sample_req_r <= 1'b1;
        end else begin
            conv_cnt_r <= conv_cnt_r - 32'h1;
            sample_req_r <= 1'b0;
        end
    end

    assign acc_nxt = acc_r + {{6{sample_data[15]}}, sample_data};
    assign acc_shifted = acc_nxt >>> sh_w;
    assign avg_val = acc_shifted[15:0];
    assign sum_wide = {avg_val[15], avg_val} + {offset_r[15], offset_r};

    tsr_offset_sat #(
        .WIDTH(16)
    ) u_sat (
        .value_in(avg_val),
        .offset_in(offset_r),
        .value_out(sat_w)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n || gcr_busy) begin
            acc_r <= 22'h0;
            samp_cnt_r <= 7'h0;
        end else if (res_stb) begin
            acc_r <= 22'h0;
            samp_cnt_r <= 7'h0;
        end else if (sample_valid) begin
            acc_r <= acc_nxt;
            samp_cnt_r <= samp_cnt_r + 7'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            temp_r <= `TSR_TEMP_RST;
            alert_n_r <= 1'b1;
        end else begin
            if (res_stb) temp_r <= sat_w;
            alert_n_r <= ~((temp_r > limit_high) | (temp_r < limit_low));
        end
    end

    assign sample_req = sample_req_r;
    assign temp_result = temp_r;
    assign alert_n = alert_n_r;
    assign soft_reset_busy = gcr_busy;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    offset_write_a: assert property (wr_off |=> offset_r == $past(wr_word)) else $error("offset not written");
    ident_store_a: assert property (word_wr && ptr_r == `TSR_OFF_IDENT |=> $stable(offset_r) && $stable(scratch2_r)
        && $stable(scratch3_r)) else $error("ident write changed state");
    ident_read_a: assert property (ptr_r == `TSR_OFF_IDENT |-> read_word == {REVISION, PART_ID})
        else $error("ident word wrong");
    locked_nv_a: assert property (wr_scr2 && !nonvolatile_write_unlock |=> $stable(nv2_r))
        else $error("locked write reached storage");
    add_offset_a: assert property (res_stb && sum_wide[16] == sum_wide[15] |=> temp_r == $past(sum_wide[15:0]))
        else $error("offset sum wrong");
    clamp_high_a: assert property (res_stb && !sum_wide[16] && sum_wide[15] |=> temp_r == 16'h7fff)
        else $error("no clamp at maximum");
    clamp_low_a: assert property (res_stb && sum_wide[16] && !sum_wide[15] |=> temp_r == 16'h8000)
        else $error("no clamp at minimum");
    alert_level_a: assert property ((temp_r > limit_high) || (temp_r < limit_low) |=> !alert_n)
        else $error("alert missing");
    gcr_restart_a: assert property ($fell(gcr_busy) && continuous_conversion_mode |-> ##[0:1] sample_req)
        else $error("sampling not restarted");
    addr_ack_a: assert property (st_r == tsr_pkg::TSR_ST_ADDR && scl_fall && byte_done && addr_match && !bus_stop
        && !bus_start |=> !sda_oe_n) else $error("own address not acknowledged");

endmodule : tsr_regs

// ===== tb/tsr_host_model.sv
// Two-wire bus host model for the sensor register bank.
`timescale 1ns/1ns
`include "tsr_consts.svh"
module tsr_host_model #(
    parameter int QTR = 4
) (
    input wire logic core_clk,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    output tsr_pkg::tsr_bus_in_type bus
);
    logic scl_r = 1'b1;
    logic low_r = 1'b0;
    // ======================================================================
    // Wire level
    // The data line is pulled up, so it reads high when nobody pulls it low.
    assign bus = {scl_r, !(low_r || (!sda_oe_n && !sda_o))};
    // ======================================================================
    // Bus cycles
    task automatic qtr();
        repeat (QTR) @(posedge core_clk);
    endtask : qtr
    // Drives one bit and returns the level seen while the clock is high.
    task automatic bit1(input logic b, output logic seen);
        low_r <= !b;
        qtr();
        scl_r <= 1'b1;
        qtr();
        #1 seen = bus.sda;
        qtr();
        scl_r <= 1'b0;
        qtr();
    endtask : bit1
    task automatic xfer(input logic [7:0] v, input logic ack_in, output logic [7:0] got, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit1(v[i], got[i]);
        end
        bit1(ack_in, ack);
    endtask : xfer
    task automatic start();
        low_r <= 1'b0;
        scl_r <= 1'b1;
        qtr();
        low_r <= 1'b1;
        qtr();
        scl_r <= 1'b0;
        qtr();
    endtask : start
    task automatic stop();
        low_r <= 1'b1;
        qtr();
        scl_r <= 1'b1;
        qtr();
        low_r <= 1'b0;
        qtr();
    endtask : stop
    task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] data,
            output logic nak);
        logic [7:0] g;
        logic [3:0] a;
        start();
        xfer({dev, 1'b0}, 1'b1, g, a[3]);
        xfer(ptr, 1'b1, g, a[2]);
        xfer(data[15:8], 1'b1, g, a[1]);
        xfer(data[7:0], 1'b1, g, a[0]);
        stop();
        nak = |a;
    endtask : write_word
    task automatic read_word(input logic [6:0] dev, input logic [7:0] ptr, output logic [15:0] data,
            output logic nak);
        logic [7:0] g;
        logic [2:0] a;
        logic n;
        start();
        xfer({dev, 1'b0}, 1'b1, g, a[2]);
        xfer(ptr, 1'b1, g, a[1]);
        stop();
        start();
        xfer({dev, 1'b1}, 1'b1, g, a[0]);
        xfer(8'hff, 1'b0, data[15:8], n);
        xfer(8'hff, 1'b1, data[7:0], n);
        stop();
        nak = |a;
    endtask : read_word
    task automatic gcall();
        logic [7:0] g;
        logic a;
        start();
        xfer({`TSR_GCALL_ADDR, 1'b0}, 1'b1, g, a);
        xfer(`TSR_GCALL_RESET_CMD, 1'b1, g, a);
        stop();
    endtask : gcall
endmodule : tsr_host_model

// ===== tb/tsr_regs_bench.sv
// Self-checking bench for the sensor register bank.
`timescale 1ns/1ns
`include "tsr_consts.svh"
module tsr_regs_bench;
    localparam int CONV = 20;
    localparam int GCR = 100;
    // Identification values are arbitrary.
    localparam logic [3:0] REV = 4'h3;
    localparam logic [11:0] PID = 12'h2c4;
    localparam logic [7:0] RW_PTR [3] = '{`TSR_OFF_SCRATCH2, `TSR_OFF_OFFSET, `TSR_OFF_SCRATCH3};
    localparam logic [15:0] RW_VAL [3] = '{16'ha55a, 16'h8001, 16'h1234};
    localparam logic [15:0] OFS [4][3] = '{'{16'h0100, 16'h0010, 16'h0110}, '{16'h7f80, 16'h0100, 16'h7fff},
        '{16'h8010, 16'hff00, 16'h8000}, '{16'hfff0, 16'h0005, 16'hfff5}};
    localparam logic [15:0] AVG_N [4] = '{16'h0001, 16'h0008, 16'h0020, 16'h0040};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    tsr_pkg::tsr_bus_in_type bus_in;
    logic sda_o;
    logic sda_oe_n;
    logic [1:0] sel = 2'h0;
    logic unlock = 1'b0;
    logic cont = 1'b1;
    logic [1:0] avg = 2'h0;
    logic signed [15:0] lim_hi = 16'h0200;
    logic signed [15:0] lim_lo = 16'hff00;
    logic sample_req;
    logic sample_valid = 1'b0;
    logic signed [15:0] sample_data = 16'h0000;
    logic signed [15:0] temp_result;
    logic alert_n;
    logic busy;
    logic [6:0] own = `TSR_ADDR_BASE;
    logic nak;
    logic exp_al;
    logic [15:0] rd;
    int err_total = 0;
    int n_compared = 0;
    int busy_len = 0;
    int n_valid = 0;
    int n;
    // ======================================================================
    // Clock, converter stand-in and counters
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        sample_valid <= sample_req;
        if (busy) begin
            busy_len <= busy_len + 1;
            n_valid <= 0;
        end else if (sample_valid) begin
            n_valid <= n_valid + 1;
        end
    end
    tsr_regs #(.CONV_CYCLES(CONV), .GCR_CYCLES(GCR), .REVISION(REV), .PART_ID(PID)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .bus_in(bus_in), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .address_select_pin(sel), .nonvolatile_write_unlock(unlock), .continuous_conversion_mode(cont),
        .avg_mode(avg), .limit_high(lim_hi), .limit_low(lim_lo), .sample_req(sample_req),
        .sample_valid(sample_valid), .sample_data(sample_data), .temp_result(temp_result),
        .alert_n(alert_n), .soft_reset_busy(busy));
    tsr_host_model host (.core_clk(core_clk), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bus(bus_in));
    // ======================================================================
    // Tasks
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
        host.write_word(own, ptr, data, nak);
        check("write ack", {15'h0000, nak}, 16'h0000);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] ptr, input logic [15:0] exp);
        host.read_word(own, ptr, rd, nak);
        check(what, rd, exp);
    endtask : rdchk
    task automatic settle(input logic [15:0] exp);
        int i;
        i = 0;
        while (temp_result !== exp && i < 3000) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        check("temp_result", temp_result, exp);
        if (i >= 3000) test_done();
    endtask : settle
    task automatic to_req(output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (sample_req !== 1'b1 && k < 1000);
        if (k >= 1000) begin
            err_total++;
            test_done();
        end
    endtask : to_req
    // ======================================================================
    // Sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdchk("offset", `TSR_OFF_OFFSET, `TSR_OFFSET_RST);
        rdchk("scratch2", `TSR_OFF_SCRATCH2, `TSR_SCRATCH_RST);
        rdchk("ident", `TSR_OFF_IDENT, {REV, PID});
        for (int k = 0; k < 3; k++) begin
            wr(RW_PTR[k], RW_VAL[k]);
            rdchk("readback", RW_PTR[k], RW_VAL[k]);
        end
        wr(`TSR_OFF_IDENT, 16'h0000);
        rdchk("ident", `TSR_OFF_IDENT, {REV, PID});
        host.write_word(own, 8'h0a, 16'h1111, nak);
        rdchk("unmapped", 8'h0a, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            sel <= c[1:0];
            own = `TSR_ADDR_BASE + 7'(c);
            @(posedge core_clk);
            host.write_word(`TSR_ADDR_BASE + 7'((c + 1) % 4), 8'h06, 16'hffff, nak);
            check("foreign ack", {15'h0000, nak}, 16'h0001);
            wr(`TSR_OFF_SCRATCH2, 16'(c));
            rdchk("select", `TSR_OFF_SCRATCH2, 16'(c));
        end
        to_req(n);
        to_req(n);
        check("request spacing", 16'(n), 16'(CONV));
        @(posedge core_clk);
        cont <= 1'b0;
        repeat (2) @(posedge core_clk);
        n = 0;
        repeat (2 * CONV) begin
            @(posedge core_clk);
            #1;
            if (sample_req !== 1'b0) n++;
        end
        check("idle requests", 16'(n), 16'h0000);
        @(posedge core_clk);
        cont <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            sample_data <= OFS[k][0];
            wr(`TSR_OFF_OFFSET, OFS[k][1]);
            settle(OFS[k][2]);
            rdchk("result", `TSR_OFF_TEMP, OFS[k][2]);
            exp_al = !($signed(OFS[k][2]) > lim_hi || $signed(OFS[k][2]) < lim_lo);
            repeat (2) @(posedge core_clk);
            check("alert_n", {15'h0000, alert_n}, {15'h0000, exp_al});
        end
        unlock <= 1'b1;
        wr(`TSR_OFF_SCRATCH3, 16'h5678);
        unlock <= 1'b0;
        wr(`TSR_OFF_SCRATCH3, 16'h9999);
        rdchk("locked", `TSR_OFF_SCRATCH3, 16'h9999);
        n = busy_len;
        host.gcall();
        repeat (GCR) @(posedge core_clk);
        check("busy length", 16'(busy_len - n), 16'(GCR));
        rdchk("reloaded", `TSR_OFF_SCRATCH3, 16'h5678);
        rdchk("scratch2 reload", `TSR_OFF_SCRATCH2, `TSR_SCRATCH_RST);
        rdchk("offset cleared", `TSR_OFF_OFFSET, `TSR_OFFSET_RST);
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            avg <= m[1:0];
            host.gcall();
            sample_data <= 16'h0040 + 16'(m);
            settle(16'h0040 + 16'(m));
            check("samples per result", 16'(n_valid), AVG_N[m]);
        end
        test_done();
    end
endmodule : tsr_regs_bench
